// *** tsf_pkg.sv ***
// constants and types shared by the timer status flag logic
`default_nettype none

package tsf_pkg;

    // ************************************************************
    // register map (byte addresses on the apb bus)
    // ************************************************************
    localparam int          ADDR_W               = 12;
    localparam logic [11:0] ADDR_TIMER_CTRL_STAT = 12'h000; // timer_control_status
    localparam logic [11:0] ADDR_IRQ_STATUS      = 12'h004; // sticky events, write one to clear
    localparam logic [11:0] ADDR_IRQ_MASK        = 12'h008; // interrupt enables

    // ************************************************************
    // field layout of timer_control_status
    // ************************************************************
    localparam int NUM_FLAGS      = 5;
    localparam int FLAG_LSB       = 3;  // flags sit in bits 7:3
    localparam int FLAG_MSB       = 7;
    localparam int FREEZE_BIT     = 2;  // timer_freeze
    localparam int RSVD_MSB       = 1;  // bits 1:0 read as zero

    // flag index inside the five-bit flag vector
    localparam int IDX_CAPTURE_A  = 4;
    localparam int IDX_COMPARE_A  = 3;
    localparam int IDX_ROLLOVER   = 2;
    localparam int IDX_CAPTURE_B  = 1;
    localparam int IDX_COMPARE_B  = 0;

    // ************************************************************
    // reset values and counter limits
    // ************************************************************
    localparam logic [4:0]  FLAGS_RESET   = 5'h00;
    localparam logic        FREEZE_RESET  = 1'b0;
    localparam logic [4:0]  MASK_RESET    = 5'h00;
    localparam logic [15:0] COUNTER_MAX   = 16'hffff;
    localparam logic [15:0] COUNTER_ZERO  = 16'h0000;

    // one bit per event flag, msb first as in the status byte
    typedef struct packed {
        logic capture_a;
        logic compare_a;
        logic rollover;
        logic capture_b;
        logic compare_b;
    } tsf_flags_t;

endpackage

`default_nettype wire

// *** tsf_status_flags.sv ***
// status, freeze control and interrupt logic of the 16-bit free-running timer
//
// The placing of the registers and register access over APB were left to the implementer.
`default_nettype none

// What this block does
// - capture_a_flag sets on a capture_input_a edge, and in pulse-width mode also on a compare_value_b match.
// - capture_a_flag clears after a status read followed by an access to capture_value_a_low.
// - compare_a_flag sets when the counter equals compare_value_a.
// - compare_a_flag clears after a status read followed by an access to compare_value_a_low.
// - rollover_flag sets when the counter wraps from ffff to 0000.
// - rollover_flag clears after a status read followed by an access to main_counter_low.
// - an access to alt_counter_low never touches rollover_flag.
// - capture_b_flag sets on a capture_input_b edge.
// - capture_b_flag clears after a status read followed by an access to capture_value_b_low.
// - compare_b_flag sets when the counter equals compare_value_b.
// - compare_b_flag clears after a status read followed by an access to compare_value_b_low.
// - timer_freeze high stops prescaler and counter and disables both compare outputs.
// - only a software write changes timer_freeze.
// - all registers stay readable and writable while frozen.
// - bits 7:3 are read-only flags, bit 2 is timer_freeze, bits 1:0 are reserved and read zero.
// - after reset timer_freeze is 0 and all flags are 0.
module tsf_status_flags (
    input  wire logic                   i_clk,
    input  wire logic                   i_nrst,
    // apb slave
    input  wire logic                   i_psel,
    input  wire logic                   i_penable,
    input  wire logic                   i_pwrite,
    input  wire logic [11:0]            i_paddr,
    input  wire logic [31:0]            i_pwdata,
    output logic      [31:0]            o_prdata,
    output logic                        o_pready,
    output logic                        o_pslverr,
    // timer core
    input  wire logic [15:0]            i_counter,
    input  wire logic [15:0]            i_compare_value_a,
    input  wire logic [15:0]            i_compare_value_b,
    input  wire logic                   i_pwm_mode,
    input  wire tsf_pkg::tsf_flags_t    i_low_access,
    input  wire logic                   i_alt_counter_low_acc,
    // capture pins
    input  wire logic                   i_capture_input_a,
    input  wire logic                   i_capture_input_b,
    // control outputs
    output logic                        o_count_enable,
    output logic                        o_compare_out_en,
    output logic                        o_irq
);

    // ************************************************************
    // bus decode
    // ************************************************************
    tsf_pkg::tsf_flags_t flags;
    logic [4:0]          arm;
    logic                freeze;
    logic [4:0]          irq_status;
    logic [4:0]          irq_mask;
    logic [15:0]         counter_prev;

    wire        bus_access   = i_psel && i_penable;
    wire        bus_done     = bus_access && o_pready;
    wire        bus_load     = bus_access && !o_pready;
    wire        sel_ctrl     = (i_paddr == tsf_pkg::ADDR_TIMER_CTRL_STAT);
    wire        sel_irq_st   = (i_paddr == tsf_pkg::ADDR_IRQ_STATUS);
    wire        sel_irq_mask = (i_paddr == tsf_pkg::ADDR_IRQ_MASK);
    wire        sel_any      = sel_ctrl || sel_irq_st || sel_irq_mask;
    wire        wr_done      = bus_done && i_pwrite;
    wire        wr_ctrl      = wr_done && sel_ctrl;
    wire        wr_irq_st    = wr_done && sel_irq_st;
    wire        wr_irq_mask  = wr_done && sel_irq_mask;
    wire        status_read  = bus_done && !i_pwrite && sel_ctrl;

    // status byte: flags, freeze, two zero bits
    wire [7:0]  ctrl_byte    = {flags, freeze, 2'b00};
    wire [31:0] read_mux     = sel_ctrl     ? {24'h000000, ctrl_byte}     :
                               sel_irq_st   ? {27'h0000000, irq_status}   :
                               sel_irq_mask ? {27'h0000000, irq_mask}     :
                                              32'h00000000;

    // ************************************************************
    // apb answer: one wait state, never gated by timer_freeze
    // ************************************************************
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata  <= 32'h00000000;
        end else begin
            o_pready  <= bus_load;
            o_pslverr <= bus_load && !sel_any;
            if (bus_load && !i_pwrite) begin
                o_prdata <= read_mux;
            end
        end
    end

    // ************************************************************
    // capture pin synchronisers and edge filter, one per channel
    // ************************************************************
    wire [1:0] cap_pin = {i_capture_input_a, i_capture_input_b};
    wire [1:0] cap_rise;

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_cap
            logic s0;
            logic s1;
            logic s2;
            logic level;
            // a change counts once the second and third stage agree
            assign cap_rise[ch] = (s1 == s2) && s2 && !level;
            always_ff @(posedge i_clk or negedge i_nrst) begin
                if (!i_nrst) begin
                    s0    <= 1'b0;
                    s1    <= 1'b0;
                    s2    <= 1'b0;
                    level <= 1'b0;
                end else begin
                    s0 <= cap_pin[ch];
                    s1 <= s0;
                    s2 <= s1;
                    if (s1 == s2) begin
                        level <= s2;
                    end
                end
            end
        end
    endgenerate

    // ************************************************************
    // event detection from the counter
    // ************************************************************
    wire cnt_moved = (i_counter != counter_prev);
    wire cmp_a_evt = cnt_moved && (i_counter == i_compare_value_a);
    wire cmp_b_evt = cnt_moved && (i_counter == i_compare_value_b);
    wire roll_evt  = (counter_prev == tsf_pkg::COUNTER_MAX) &&
                     (i_counter == tsf_pkg::COUNTER_ZERO);
    wire cap_a_evt = cap_rise[1] || (i_pwm_mode && cmp_b_evt);
    wire cap_b_evt = cap_rise[0];

    // event and clearing access vectors, same order as the flags
    wire [4:0] evt = {cap_a_evt, cmp_a_evt, roll_evt, cap_b_evt, cmp_b_evt};
    // alt_counter_low is deliberately absent from the clearing vector
    wire [4:0] acc = i_low_access;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            counter_prev <= tsf_pkg::COUNTER_ZERO;
        end else begin
            counter_prev <= i_counter;
        end
    end

    // ************************************************************
    // event flags: set wins, clear needs an armed status read
    // ************************************************************
    logic [4:0] next_flags;
    logic [4:0] next_arm;

    generate
        for (ch = 0; ch < tsf_pkg::NUM_FLAGS; ch = ch + 1) begin : g_flag
            assign next_flags[ch] = evt[ch] || (flags[ch] && !(arm[ch] && acc[ch]));
            // arm with what software actually saw in the status byte
            assign next_arm[ch]   = status_read ? o_prdata[tsf_pkg::FLAG_LSB + ch] :
                                                  (arm[ch] && !acc[ch]);
        end
    endgenerate

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            flags <= tsf_pkg::FLAGS_RESET;
            arm   <= 5'h00;
        end else begin
            flags <= next_flags;
            arm   <= next_arm;
        end
    end

    // ************************************************************
    // timer_freeze and the gated timer controls
    // ************************************************************
    wire next_freeze = wr_ctrl ? i_pwdata[tsf_pkg::FREEZE_BIT] : freeze;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            freeze           <= tsf_pkg::FREEZE_RESET;
            o_count_enable   <= 1'b1;
            o_compare_out_en <= 1'b1;
        end else begin
            freeze           <= next_freeze;
            o_count_enable   <= !next_freeze;
            o_compare_out_en <= !next_freeze;
        end
    end

    // ************************************************************
    // interrupt status, mask and output
    // ************************************************************
    wire [4:0] w1c_bits       = wr_irq_st ? i_pwdata[4:0] : 5'h00;
    wire [4:0] next_irq_st    = evt | (irq_status & ~w1c_bits);
    wire [4:0] next_irq_mask  = wr_irq_mask ? i_pwdata[4:0] : irq_mask;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            irq_status <= 5'h00;
            irq_mask   <= tsf_pkg::MASK_RESET;
            o_irq      <= 1'b0;
        end else begin
            irq_status <= next_irq_st;
            irq_mask   <= next_irq_mask;
            o_irq      <= |(irq_status & irq_mask);
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_nrst);

    sequence s_arm_clear(int idx);
        arm[idx] && acc[idx] && !evt[idx];
    endsequence

    sequence s_set_and_clear(int idx);
        evt[idx] && arm[idx] && acc[idx];
    endsequence

    a_cap_a_set: assert property (
        (cap_rise[1] || (i_pwm_mode && cmp_b_evt)) |=> flags.capture_a)
        else $error("capture_a_flag not set after capture event");

    a_cap_a_clear: assert property (
        s_arm_clear(tsf_pkg::IDX_CAPTURE_A) |=> !flags.capture_a)
        else $error("capture_a_flag not cleared by armed access");

    a_cmp_a_set: assert property (
        (cnt_moved && i_counter == i_compare_value_a) |=> flags.compare_a)
        else $error("compare_a_flag not set on match");

    a_cmp_a_clear: assert property (
        s_arm_clear(tsf_pkg::IDX_COMPARE_A) |=> !flags.compare_a)
        else $error("compare_a_flag not cleared by armed access");

    a_roll_set: assert property (
        (counter_prev == tsf_pkg::COUNTER_MAX && i_counter == tsf_pkg::COUNTER_ZERO)
            |=> flags.rollover)
        else $error("rollover_flag not set on wrap");

    a_roll_clear: assert property (
        s_arm_clear(tsf_pkg::IDX_ROLLOVER) |=> !flags.rollover)
        else $error("rollover_flag not cleared by armed access");

    a_alt_keeps_roll: assert property (
        (flags.rollover && i_alt_counter_low_acc && !i_low_access.rollover) |=> flags.rollover)
        else $error("alt counter access changed rollover_flag");

    a_cap_b_set: assert property (
        $rose(cap_rise[0]) |=> flags.capture_b)
        else $error("capture_b_flag not set after capture event");

    a_cap_b_clear: assert property (
        s_arm_clear(tsf_pkg::IDX_CAPTURE_B) |=> !flags.capture_b)
        else $error("capture_b_flag not cleared by armed access");

    a_cmp_b_set: assert property (
        (cnt_moved && i_counter == i_compare_value_b) |=> flags.compare_b)
        else $error("compare_b_flag not set on match");

    a_cmp_b_clear: assert property (
        s_arm_clear(tsf_pkg::IDX_COMPARE_B) |=> !flags.compare_b)
        else $error("compare_b_flag not cleared by armed access");

    a_freeze_stops: assert property (
        (wr_ctrl && i_pwdata[tsf_pkg::FREEZE_BIT]) |=> (!o_count_enable && !o_compare_out_en))
        else $error("freeze write did not stop the timer");

    a_freeze_runs: assert property (
        (wr_ctrl && !i_pwdata[tsf_pkg::FREEZE_BIT]) |=> (o_count_enable && o_compare_out_en && !freeze))
        else $error("freeze clear did not restart the timer");

    a_freeze_sw_only: assert property (
        !wr_ctrl |=> $stable(freeze))
        else $error("timer_freeze changed without a write");

    a_bus_answers: assert property (
        (bus_load && freeze) |=> o_pready)
        else $error("bus not answered while frozen");

    a_status_layout: assert property (
        (bus_done && !i_pwrite && sel_ctrl) |-> (o_prdata[1:0] == 2'b00))
        else $error("reserved status bits not zero");

    a_flags_read_only: assert property (
        (wr_ctrl && evt == 5'h00 && acc == 5'h00) |=> $stable(flags))
        else $error("status write altered an event flag");

    a_no_clear_unarmed: assert property (
        (flags.compare_a && !arm[tsf_pkg::IDX_COMPARE_A] && !status_read) |=> flags.compare_a)
        else $error("compare_a_flag cleared without status read");

    a_set_wins: assert property (
        (s_set_and_clear(tsf_pkg::IDX_ROLLOVER) ##0 !status_read) |=> flags.rollover [*2])
        else $error("clear beat a coincident rollover event");

    a_irq_level: assert property (
        (|(irq_status & irq_mask)) |=> o_irq)
        else $error("interrupt output not raised");

    // set beats a coincident armed clear on the other four flags
    a_cap_a_wins: assert property (
        s_set_and_clear(tsf_pkg::IDX_CAPTURE_A) |=> flags.capture_a)
        else $error("clear beat a coincident capture_a event");

    a_cmp_a_wins: assert property (
        s_set_and_clear(tsf_pkg::IDX_COMPARE_A) |=> flags.compare_a)
        else $error("clear beat a coincident compare_a event");

    a_cap_b_wins: assert property (
        s_set_and_clear(tsf_pkg::IDX_CAPTURE_B) |=> flags.capture_b)
        else $error("clear beat a coincident capture_b event");

    a_cmp_b_wins: assert property (
        s_set_and_clear(tsf_pkg::IDX_COMPARE_B) |=> flags.compare_b)
        else $error("clear beat a coincident compare_b event");

    // an unarmed flag survives any low-byte access
    a_cap_a_held: assert property (
        (flags.capture_a && !arm[tsf_pkg::IDX_CAPTURE_A] && !status_read) |=> flags.capture_a)
        else $error("capture_a_flag cleared without status read");

    a_roll_held: assert property (
        (flags.rollover && !arm[tsf_pkg::IDX_ROLLOVER] && !status_read) |=> flags.rollover)
        else $error("rollover_flag cleared without status read");

    a_cap_b_held: assert property (
        (flags.capture_b && !arm[tsf_pkg::IDX_CAPTURE_B] && !status_read) |=> flags.capture_b)
        else $error("capture_b_flag cleared without status read");

    a_cmp_b_held: assert property (
        (flags.compare_b && !arm[tsf_pkg::IDX_COMPARE_B] && !status_read) |=> flags.compare_b)
        else $error("compare_b_flag cleared without status read");

    a_arm_from_read: assert property (
        status_read |=> (arm == $past(o_prdata[tsf_pkg::FLAG_MSB:tsf_pkg::FLAG_LSB])))
        else $error("status read did not arm the shown flags");

    a_freeze_outputs: assert property (
        (o_count_enable == !freeze) && (o_compare_out_en == !freeze))
        else $error("timer controls disagree with timer_freeze");

    a_irq_low: assert property (
        !(|(irq_status & irq_mask)) |=> !o_irq)
        else $error("interrupt output raised with nothing pending");

    a_irq_sticky: assert property (
        !wr_irq_st |=> ((irq_status & $past(irq_status)) == $past(irq_status)))
        else $error("interrupt status bit lost without a clear");

    a_irq_w1c: assert property (
        (wr_irq_st && evt == 5'h00) |=> ((irq_status & $past(i_pwdata[4:0])) == 5'h00))
        else $error("write one did not clear interrupt status");

    a_unmapped_err: assert property (
        (bus_load && !sel_any) |=> (o_pready && o_pslverr))
        else $error("unmapped access not flagged");

    a_pready_pulse: assert property (
        o_pready |=> !o_pready)
        else $error("bus answer longer than one cycle");

endmodule

`default_nettype wire

// *** tsf_core_model.sv ***
// behavioural model of the timer core that feeds the status flag logic
`default_nettype none

module tsf_core_model (
    input  wire logic        i_clk,
    input  wire logic        i_nrst,
    input  wire logic        i_count_enable,
    input  wire logic        i_load,
    input  wire logic [15:0] i_load_value,
    output logic      [15:0] o_counter
);
    timeunit 1ns;
    timeprecision 1ns;

    // ************************************************************
    // free-running counter
    // ************************************************************
    // a load wins so the bench can place the counter near a boundary
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_counter <= 16'h0000;
        end else if (i_load) begin
            o_counter <= i_load_value;
        end else if (i_count_enable) begin
            o_counter <= o_counter + 16'h0001;
        end
    end
endmodule

`default_nettype wire

// *** tsf_status_flags_test.sv ***
// self-checking bench for the timer status flag logic
`default_nettype none
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin errors++; $display("FAIL %s exp %h got %h", nm, ex, got); end end

module tsf_status_flags_test;
    timeunit 1ns;
    timeprecision 1ns;

    // ************************************************************
    // signals
    // ************************************************************
    logic                clk, nrst, psel, penable, pwrite, pready, pslverr, err;
    logic                pwm, cap_a, cap_b, alt_acc, load, cnt_en, cmp_en, irq;
    logic [11:0]         paddr;
    logic [31:0]         pwdata, prdata, rd;
    logic [15:0]         cnt, cmp_a, cmp_b, load_val;
    tsf_pkg::tsf_flags_t low_acc;
    int                  errors, cmp_count, cyc, seed, k;

    tsf_status_flags dut (
        .i_clk(clk), .i_nrst(nrst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_counter(cnt),
        .i_compare_value_a(cmp_a), .i_compare_value_b(cmp_b), .i_pwm_mode(pwm),
        .i_low_access(low_acc), .i_alt_counter_low_acc(alt_acc),
        .i_capture_input_a(cap_a), .i_capture_input_b(cap_b),
        .o_count_enable(cnt_en), .o_compare_out_en(cmp_en), .o_irq(irq)
    );

    tsf_core_model core (
        .i_clk(clk), .i_nrst(nrst), .i_count_enable(cnt_en), .i_load(load),
        .i_load_value(load_val), .o_counter(cnt)
    );

    // ************************************************************
    // clock and timeout
    // ************************************************************
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            conclude();
        end
    end

    // ************************************************************
    // tasks
    // ************************************************************
    // closing report and verdict
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // one apb transfer, idle edge after release
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            errors++;
            conclude();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    // one-cycle low-byte access strobe for one flag
    task automatic pulse_low(input int idx);
        low_acc <= tsf_pkg::tsf_flags_t'(5'h01 << idx);
        @(posedge clk);
        low_acc <= '0;
    endtask

    // raise one event, then walk the clearing sequence
    task automatic flag_test(input int idx, input logic via_pwm);
        logic [7:0] m;
        m = 8'h01 << (tsf_pkg::FLAG_LSB + idx);
        k = 4 + ($random(seed) & 7);
        case (idx)
            tsf_pkg::IDX_CAPTURE_A: begin
                pwm <= via_pwm;
                if (via_pwm) cmp_b <= cnt + 16'(k);
                else cap_a <= 1'b1;
            end
            tsf_pkg::IDX_COMPARE_A: cmp_a <= cnt + 16'(k);
            tsf_pkg::IDX_ROLLOVER: begin
                load <= 1'b1;
                load_val <= 16'hffff - 16'(k);
            end
            tsf_pkg::IDX_CAPTURE_B: cap_b <= 1'b1;
            default: cmp_b <= cnt + 16'(k);
        endcase
        @(posedge clk);
        load <= 1'b0;
        repeat (k + 6) @(posedge clk);
        cap_a <= 1'b0;
        cap_b <= 1'b0;
        pwm <= 1'b0;
        pulse_low(idx);
        apb(1'b0, tsf_pkg::ADDR_TIMER_CTRL_STAT, '0);
        `CHK("flag set", m, rd[7:0] & m)
        alt_acc <= 1'b1;
        @(posedge clk);
        alt_acc <= 1'b0;
        apb(1'b0, tsf_pkg::ADDR_TIMER_CTRL_STAT, '0);
        `CHK("flag after alt", m, rd[7:0] & m)
        pulse_low(idx);
        apb(1'b0, tsf_pkg::ADDR_TIMER_CTRL_STAT, '0);
        `CHK("flag cleared", 8'h00, rd[7:0] & m)
    endtask

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        seed = 32'ha162;
        errors = 0;
        cmp_count = 0;
        cyc = 0;
        nrst = 1'b0;
        {psel, penable, pwrite, pwm, cap_a, cap_b, alt_acc, load} = '0;
        paddr = '0;
        pwdata = '0;
        load_val = '0;
        cmp_a = 16'h8000;
        cmp_b = 16'h9000;
        low_acc = '0;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        `CHK("count enable", 1'b1, cnt_en)
        apb(1'b0, tsf_pkg::ADDR_TIMER_CTRL_STAT, '0);
        `CHK("ctrl reset", 8'h00, rd[7:0])
        for (int i = 0; i < tsf_pkg::NUM_FLAGS; i++) flag_test(i, 1'b0);
        flag_test(tsf_pkg::IDX_CAPTURE_A, 1'b1);
        // interrupt status, mask and clear
        apb(1'b0, tsf_pkg::ADDR_IRQ_STATUS, '0);
        `CHK("irq status", 32'h0000001f, rd)
        `CHK("irq masked", 1'b0, irq)
        apb(1'b1, tsf_pkg::ADDR_IRQ_MASK, 32'h0000001f);
        repeat (2) @(posedge clk);
        `CHK("irq raised", 1'b1, irq)
        apb(1'b1, tsf_pkg::ADDR_IRQ_STATUS, 32'h0000001f);
        repeat (2) @(posedge clk);
        `CHK("irq cleared", 1'b0, irq)
        // unmapped address
        apb(1'b0, 12'h00c, '0);
        `CHK("unmapped err", 1'b1, err)
        `CHK("unmapped data", 32'h00000000, rd)
        // clear flags left over by earlier scenarios
        apb(1'b0, tsf_pkg::ADDR_TIMER_CTRL_STAT, '0);
        low_acc <= '1;
        @(posedge clk);
        low_acc <= '0;
        // freeze with flag bits written as ones, reserved bits kept zero
        apb(1'b1, tsf_pkg::ADDR_TIMER_CTRL_STAT, 32'h000000fc);
        apb(1'b0, tsf_pkg::ADDR_TIMER_CTRL_STAT, '0);
        `CHK("ctrl frozen", 8'h04, rd[7:0])
        `CHK("count stopped", 1'b0, cnt_en)
        `CHK("outputs off", 1'b0, cmp_en)
        k = int'(cnt);
        cap_b <= 1'b1;
        repeat (8) @(posedge clk);
        cap_b <= 1'b0;
        `CHK("counter held", 16'(k), cnt)
        apb(1'b0, tsf_pkg::ADDR_TIMER_CTRL_STAT, '0);
        `CHK("freeze kept", 1'b1, rd[tsf_pkg::FREEZE_BIT])
        apb(1'b1, tsf_pkg::ADDR_TIMER_CTRL_STAT, '0);
        `CHK("count resumed", 1'b1, cnt_en)
        `CHK("outputs on", 1'b1, cmp_en)
        // armed clear meeting a rollover in the same cycle
        k = 4 + ($random(seed) & 7);
        load <= 1'b1;
        load_val <= 16'hffff - 16'(k);
        @(posedge clk);
        load <= 1'b0;
        repeat (k + 3) @(posedge clk);
        apb(1'b0, tsf_pkg::ADDR_TIMER_CTRL_STAT, '0);
        `CHK("rollover armed", 8'h20, rd[7:0] & 8'h20)
        load <= 1'b1;
        @(posedge clk);
        load <= 1'b0;
        repeat (k + 1) @(posedge clk);
        pulse_low(tsf_pkg::IDX_ROLLOVER);
        apb(1'b0, tsf_pkg::ADDR_TIMER_CTRL_STAT, '0);
        `CHK("set wins", 8'h20, rd[7:0] & 8'h20)
        // second reset in mid-run with flags standing
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        apb(1'b0, tsf_pkg::ADDR_TIMER_CTRL_STAT, '0);
        `CHK("ctrl after reset", 8'h00, rd[7:0])
        conclude();
    end
endmodule

`undef CHK
`default_nettype wire
